// >>> pkg/monitor_regs_pkg.sv
// shared constants for the monitor status and configuration registers
package monitor_regs_pkg;

  // register byte offsets
  localparam logic [7:0] STATUS_CONTROL_ADDR = 8'he2;
  localparam logic [7:0] CONFIGURATION_ADDR  = 8'he3;

  // manager-side error status window, read clear and write-one clear apply here
  localparam logic [7:0] MANAGER_STATUS_FIRST = 8'h51;
  localparam logic [7:0] MANAGER_STATUS_LAST  = 8'h57;

  // reset values
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIGURATION_RESET  = 8'h00;

  // status/control field positions
  localparam int STAT_PWM_OVERRIDE_BIT  = 0;
  localparam int STAT_CLEAR_ON_READ_BIT = 1;
  localparam int STAT_INPUT4_AM_BIT     = 2;
  localparam int STAT_INPUT5_AM_BIT     = 3;
  localparam int STAT_TACH_EDGE_LSB     = 4;
  localparam int STAT_HOST_SUMMARY_BIT  = 6;
  localparam int STAT_MGR_SUMMARY_BIT   = 7;

  // configuration field positions
  localparam int CFG_START_BIT      = 0;
  localparam int CFG_LOCK_BIT       = 1;
  localparam int CFG_GLOBAL_MASK    = 2;
  localparam int CFG_ALERT_EN_BIT   = 3;
  localparam int CFG_THROTTLE_TIE   = 4;
  localparam int CFG_ALERT_COMP_BIT = 5;
  localparam int CFG_RESERVED_BIT   = 6;
  localparam int CFG_READY_BIT      = 7;

  // tachometer edge selection codes
  localparam logic [1:0] EDGE_EITHER  = 2'h0;
  localparam logic [1:0] EDGE_RISING  = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_RESVD   = 2'h3;

  // duty cycle extremes
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] DUTY_OFF  = 8'h00;

  // channel counts
  localparam int PWM_COUNT  = 2;
  localparam int TACH_COUNT = 4;

endpackage

// >>> pkg/monitor_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
// control lines from the register bank to the fan and tach helpers
interface monitor_ctrl_if;
  logic       start;
  logic       pwm_override;
  logic [1:0] tach_edge;

  modport bank
  (
    output start,
    output pwm_override,
    output tach_edge
  );
  modport user
  (
    input start,
    input pwm_override,
    input tach_edge
  );
endinterface
`default_nettype wire

// >>> rtl/fan_duty_gate.sv
`timescale 1ns/1ps
`default_nettype none
// final duty stage between the fan algorithm and the pwm engines
module fan_duty_gate
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  monitor_ctrl_if.user     ctrl,
  input  wire logic [15:0] duty_request_in,
  output logic      [15:0] duty_out
);

  typedef struct packed {
    logic [15:0] duty;
  } state_type;

  state_type state;
  state_type next_state;

  // override forces full duty, otherwise basic mode forces off
  always_comb
  begin
    next_state = state;
    for (int i = 0; i < monitor_regs_pkg::PWM_COUNT; i++)
    begin
      if (ctrl.pwm_override)
        next_state.duty[i*8 +: 8] = monitor_regs_pkg::DUTY_FULL;
      else if (!ctrl.start)
        next_state.duty[i*8 +: 8] = monitor_regs_pkg::DUTY_OFF;
      else
        next_state.duty[i*8 +: 8] = duty_request_in[i*8 +: 8];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign duty_out = state.duty;

endmodule
`default_nettype wire

// >>> rtl/tach_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
// turns tach levels into one-cycle count pulses per selected edge
module tach_edge_detect
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  monitor_ctrl_if.user    ctrl,
  input  wire logic [3:0] tach_in,
  output logic      [3:0] tach_pulse_out
);

  typedef struct packed {
    logic [3:0] last;
    logic [3:0] pulse;
    logic       primed;
  } state_type;

  state_type state;
  state_type next_state;
  logic [3:0] rise;
  logic [3:0] fall;

  // per-input edge classification
  genvar g;
  generate
    for (g = 0; g < monitor_regs_pkg::TACH_COUNT; g++)
    begin : g_tach
      assign rise[g] = tach_in[g] & ~state.last[g];
      assign fall[g] = ~tach_in[g] & state.last[g];
    end
  endgenerate

  // pick the edges to count
  always_comb
  begin
    next_state = state;
    next_state.last = tach_in;
    unique case (ctrl.tach_edge)
      monitor_regs_pkg::EDGE_RISING:  next_state.pulse = rise;
      monitor_regs_pkg::EDGE_FALLING: next_state.pulse = fall;
      monitor_regs_pkg::EDGE_RESVD:   next_state.pulse = rise | fall;
      monitor_regs_pkg::EDGE_EITHER:  next_state.pulse = rise | fall;
    endcase
    // no false edge from the reset value of last
    next_state.primed = 1'b1;
    if (!state.primed)
      next_state.pulse = '0;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign tach_pulse_out = state.pulse;

endmodule
`default_nettype wire

// >>> rtl/monitor_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_status_config_regs
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // byte register port from the serial engine
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  // state of the error status bank
  input  wire logic        host_status_any_in,
  input  wire logic        manager_status_any_in,
  input  wire logic        host_input4_fault_flag_in,
  input  wire logic        manager_input4_fault_flag_in,
  input  wire logic        host_input5_fault_flag_in,
  input  wire logic        manager_input5_fault_flag_in,
  input  wire logic        general_input_4_event_in,
  input  wire logic        general_input_5_event_in,
  input  wire logic        data_ready_in,
  // commands to the error status bank
  output logic             manager_read_clear_out,
  output logic             manager_write_clear_out,
  output logic      [7:0]  manager_clear_bits_out,
  output logic      [7:0]  manager_clear_addr_out,
  output logic             manager_record_enable_out,
  output logic             host_record_enable_out,
  output logic             other_events_enable_out,
  // fan and tach paths
  input  wire logic [15:0] duty_request_in,
  output logic      [15:0] duty_out,
  input  wire logic [3:0]  tach_in,
  output logic      [3:0]  tach_pulse_out,
  output logic             fan_auto_enable_out,
  // miscellaneous controls
  output logic             throttle_pin_tie_out,
  output logic             alert_comparator_mode_out,
  output logic             alert_out
);

  typedef struct packed {
    logic       pwm_full_override;
    logic       clear_on_read_mode;
    logic       input4_auto_mask;
    logic       input5_auto_mask;
    logic [1:0] tach_edge;
    logic       start;
    logic       lock;
    logic       global_event_mask;
    logic       alert_enable;
    logic       throttle_pin_tie;
    logic       alert_comp_mode;
    logic       reserved_cfg;
    logic       mgr_hold4;
    logic       host_hold4;
    logic       mgr_hold5;
    logic       host_hold5;
    logic       mgr_flag4_last;
    logic       host_flag4_last;
    logic       mgr_flag5_last;
    logic       host_flag5_last;
    logic [7:0] rdata;
    logic       rd_clear;
    logic       wr_clear;
    logic [7:0] clear_bits;
    logic [7:0] clear_addr;
    logic       alert;
  } state_type;

  state_type state;
  state_type next_state;

  logic [7:0] status_view;
  logic [7:0] config_view;
  logic       in_mgr_window;
  logic       hit_status;
  logic       hit_config;
  logic       events_live;
  logic       mgr_held;
  logic       host_held;

  monitor_ctrl_if ctrl ();

  always_comb
  begin
    status_view = '0;
    status_view[monitor_regs_pkg::STAT_PWM_OVERRIDE_BIT]  = state.pwm_full_override;
    status_view[monitor_regs_pkg::STAT_CLEAR_ON_READ_BIT] = state.clear_on_read_mode;
    status_view[monitor_regs_pkg::STAT_INPUT4_AM_BIT]     = state.input4_auto_mask;
    status_view[monitor_regs_pkg::STAT_INPUT5_AM_BIT]     = state.input5_auto_mask;
    status_view[monitor_regs_pkg::STAT_TACH_EDGE_LSB +: 2] = state.tach_edge;
    status_view[monitor_regs_pkg::STAT_HOST_SUMMARY_BIT]  = host_status_any_in;
    status_view[monitor_regs_pkg::STAT_MGR_SUMMARY_BIT]   = manager_status_any_in;
  end

  always_comb
  begin
    config_view = '0;
    config_view[monitor_regs_pkg::CFG_START_BIT]      = state.start;
    config_view[monitor_regs_pkg::CFG_LOCK_BIT]       = state.lock;
    config_view[monitor_regs_pkg::CFG_GLOBAL_MASK]    = state.global_event_mask;
    config_view[monitor_regs_pkg::CFG_ALERT_EN_BIT]   = state.alert_enable;
    config_view[monitor_regs_pkg::CFG_THROTTLE_TIE]   = state.throttle_pin_tie;
    config_view[monitor_regs_pkg::CFG_ALERT_COMP_BIT] = state.alert_comp_mode;
    config_view[monitor_regs_pkg::CFG_RESERVED_BIT]   = state.reserved_cfg;
    config_view[monitor_regs_pkg::CFG_READY_BIT]      = data_ready_in;
  end

  // address decode
  assign hit_status    = (reg_addr_in == monitor_regs_pkg::STATUS_CONTROL_ADDR);
  assign hit_config    = (reg_addr_in == monitor_regs_pkg::CONFIGURATION_ADDR);
  assign in_mgr_window = (reg_addr_in >= monitor_regs_pkg::MANAGER_STATUS_FIRST)
                       && (reg_addr_in <= monitor_regs_pkg::MANAGER_STATUS_LAST);

  assign events_live = state.start & ~state.global_event_mask;
  assign mgr_held    = state.mgr_hold4 | state.mgr_hold5;
  assign host_held   = state.host_hold4 | state.host_hold5;

  // register writes, reads, auto-mask tracking and alert
  always_comb
  begin
    next_state = state;
    next_state.rd_clear = 1'b0;
    next_state.wr_clear = 1'b0;

    // status/control write
    if (reg_write_in && hit_status)
    begin
      next_state.pwm_full_override = reg_wdata_in[monitor_regs_pkg::STAT_PWM_OVERRIDE_BIT];
      if (!state.lock)
        next_state.clear_on_read_mode = reg_wdata_in[monitor_regs_pkg::STAT_CLEAR_ON_READ_BIT];
      next_state.input4_auto_mask = reg_wdata_in[monitor_regs_pkg::STAT_INPUT4_AM_BIT];
      next_state.input5_auto_mask = reg_wdata_in[monitor_regs_pkg::STAT_INPUT5_AM_BIT];
      next_state.tach_edge = reg_wdata_in[monitor_regs_pkg::STAT_TACH_EDGE_LSB +: 2];
    end

    // configuration write
    if (reg_write_in && hit_config)
    begin
      if (!state.lock)
      begin
        next_state.start = reg_wdata_in[monitor_regs_pkg::CFG_START_BIT];
        next_state.lock  = reg_wdata_in[monitor_regs_pkg::CFG_LOCK_BIT];
      end
      next_state.global_event_mask = reg_wdata_in[monitor_regs_pkg::CFG_GLOBAL_MASK];
      next_state.alert_enable      = reg_wdata_in[monitor_regs_pkg::CFG_ALERT_EN_BIT];
      next_state.throttle_pin_tie  = reg_wdata_in[monitor_regs_pkg::CFG_THROTTLE_TIE];
      next_state.alert_comp_mode   = reg_wdata_in[monitor_regs_pkg::CFG_ALERT_COMP_BIT];
      next_state.reserved_cfg      = reg_wdata_in[monitor_regs_pkg::CFG_RESERVED_BIT];
    end

    // read data, captured one cycle after the strobe
    if (reg_read_in)
    begin
      if (hit_status)
        next_state.rdata = status_view;
      else if (hit_config)
        next_state.rdata = config_view;
      else
        next_state.rdata = 8'h00;
    end

    if (reg_read_in && in_mgr_window && state.clear_on_read_mode)
    begin
      next_state.rd_clear   = 1'b1;
      next_state.clear_addr = reg_addr_in;
      next_state.clear_bits = 8'hff;
    end

    if (reg_write_in && in_mgr_window && !state.clear_on_read_mode)
    begin
      next_state.wr_clear   = 1'b1;
      next_state.clear_addr = reg_addr_in;
      next_state.clear_bits = reg_wdata_in;
    end

    // flag history for clear detection
    next_state.mgr_flag4_last  = manager_input4_fault_flag_in;
    next_state.host_flag4_last = host_input4_fault_flag_in;
    next_state.mgr_flag5_last  = manager_input5_fault_flag_in;
    next_state.host_flag5_last = host_input5_fault_flag_in;

    if (state.mgr_flag4_last && !manager_input4_fault_flag_in)
      next_state.mgr_hold4 = 1'b0;
    if (state.host_flag4_last && !host_input4_fault_flag_in)
      next_state.host_hold4 = 1'b0;
    if (state.mgr_flag5_last && !manager_input5_fault_flag_in)
      next_state.mgr_hold5 = 1'b0;
    if (state.host_flag5_last && !host_input5_fault_flag_in)
      next_state.host_hold5 = 1'b0;

    // input 4 and input 5 triggers
    // a trigger in the same cycle as a release wins
    if (state.input4_auto_mask && general_input_4_event_in && events_live)
    begin
      next_state.mgr_hold4  = 1'b1;
      next_state.host_hold4 = 1'b1;
    end
    if (state.input5_auto_mask && general_input_5_event_in && events_live)
    begin
      next_state.mgr_hold5  = 1'b1;
      next_state.host_hold5 = 1'b1;
    end

    next_state.alert = state.alert_enable & manager_status_any_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state <= '0;
      state.pwm_full_override <= monitor_regs_pkg::STATUS_CONTROL_RESET[0];
      state.start             <= monitor_regs_pkg::CONFIGURATION_RESET[0];
    end
    else
      state <= next_state;
  end

  // control lines to the helpers
  assign ctrl.start        = state.start;
  assign ctrl.pwm_override = state.pwm_full_override;
  assign ctrl.tach_edge    = state.tach_edge;

  // final duty stage
  fan_duty_gate u_duty
  (
    .clk_in          (clk_in),
    .arst_n_in       (arst_n_in),
    .ctrl            (ctrl),
    .duty_request_in (duty_request_in),
    .duty_out        (duty_out)
  );

  // tach edge pulses
  tach_edge_detect u_tach
  (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .ctrl           (ctrl),
    .tach_in        (tach_in),
    .tach_pulse_out (tach_pulse_out)
  );

  // register-driven outputs
  assign reg_rdata_out           = state.rdata;
  assign manager_read_clear_out  = state.rd_clear;
  assign manager_write_clear_out = state.wr_clear;
  assign manager_clear_bits_out  = state.clear_bits;
  assign manager_clear_addr_out  = state.clear_addr;
  assign alert_out               = state.alert;
  assign throttle_pin_tie_out    = state.throttle_pin_tie;
  assign alert_comparator_mode_out = state.alert_comp_mode;
  assign fan_auto_enable_out     = state.start;

  // event enables towards the status bank
  // manager and host record holds, other events held by either
  assign manager_record_enable_out = events_live & ~mgr_held;
  assign host_record_enable_out    = events_live & ~host_held;
  assign other_events_enable_out   = events_live & ~mgr_held & ~host_held;

endmodule
`default_nettype wire

// >>> tb/monitor_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches the bank ports, mirrors the writable control bits
module monitor_regs_properties
(
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        host_status_any_in,
  input wire logic        manager_status_any_in,
  input wire logic        general_input_4_event_in,
  input wire logic        general_input_5_event_in,
  input wire logic        data_ready_in,
  input wire logic        manager_read_clear_out,
  input wire logic        manager_write_clear_out,
  input wire logic [7:0]  manager_clear_bits_out,
  input wire logic [7:0]  manager_clear_addr_out,
  input wire logic        manager_record_enable_out,
  input wire logic        host_record_enable_out,
  input wire logic        other_events_enable_out,
  input wire logic [15:0] duty_request_in,
  input wire logic [15:0] duty_out,
  input wire logic [3:0]  tach_in,
  input wire logic [3:0]  tach_pulse_out,
  input wire logic        alert_out
);
  logic [7:0] sc;
  logic [7:0] cf;
  logic [3:0] tq;
  logic       tv;
  logic       win;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // manager status address window
  assign win = reg_addr_in >= 8'h51 && reg_addr_in <= 8'h57;
  // shadow of both control bytes, lock honoured
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sc <= 8'h00;
      cf <= 8'h00;
      tq <= 4'h0;
      tv <= 1'b0;
    end
    else
    begin
      tq <= tach_in;
      tv <= 1'b1;
      if (reg_write_in && reg_addr_in == 8'he2)
        sc <= {2'h0, reg_wdata_in[5:2], cf[1] ? sc[1] : reg_wdata_in[1], reg_wdata_in[0]};
      if (reg_write_in && reg_addr_in == 8'he3)
        cf <= {1'b0, reg_wdata_in[6:2], cf[1] ? cf[1:0] : reg_wdata_in[1:0]};
    end
  end
  property p_full;
    sc[0] |=> duty_out == 16'hffff;
  endproperty
  a_full: assert property (p_full) else $error("duty not full");
  property p_off;
    !sc[0] && !cf[0] |=> duty_out == 16'h0000;
  endproperty
  a_off: assert property (p_off) else $error("duty not off");
  property p_pass;
    !sc[0] && cf[0] |=> duty_out == $past(duty_request_in);
  endproperty
  a_pass: assert property (p_pass) else $error("duty not passed");
  property p_basic;
    !cf[0] |-> !(other_events_enable_out || manager_record_enable_out || host_record_enable_out);
  endproperty
  a_basic: assert property (p_basic) else $error("events open while stopped");
  property p_gmask;
    cf[2] |-> !other_events_enable_out;
  endproperty
  a_gmask: assert property (p_gmask) else $error("events open under mask");
  property p_hold;
    cf[0] && !cf[2] && (sc[2] && general_input_4_event_in || sc[3] && general_input_5_event_in)
      |=> !other_events_enable_out && !manager_record_enable_out && !host_record_enable_out;
  endproperty
  a_hold: assert property (p_hold) else $error("auto mask missed");
  property p_alert;
    alert_out == $past(cf[3] && manager_status_any_in);
  endproperty
  a_alert: assert property (p_alert) else $error("alert level wrong");
  property p_rclr;
    sc[1] && reg_read_in && win |=> manager_read_clear_out && manager_clear_addr_out == $past(reg_addr_in);
  endproperty
  a_rclr: assert property (p_rclr) else $error("read clear missed");
  property p_wclr;
    !sc[1] && reg_write_in && win |=> manager_write_clear_out && manager_clear_bits_out == $past(reg_wdata_in);
  endproperty
  a_wclr: assert property (p_wclr) else $error("write clear missed");
  property p_noclr;
    manager_read_clear_out || manager_write_clear_out
      |-> $past(win && (reg_read_in && sc[1] || reg_write_in && !sc[1]));
  endproperty
  a_noclr: assert property (p_noclr) else $error("clear without cause");
  property p_rd2;
    reg_read_in && reg_addr_in == 8'he2
      |=> reg_rdata_out == {$past(manager_status_any_in), $past(host_status_any_in), $past(sc[5:0])};
  endproperty
  a_rd2: assert property (p_rd2) else $error("status byte wrong");
  property p_rd3;
    reg_read_in && reg_addr_in == 8'he3 |=> reg_rdata_out == {$past(data_ready_in), $past(cf[6:0])};
  endproperty
  a_rd3: assert property (p_rd3) else $error("config byte wrong");
  property p_tach;
    tach_pulse_out == $past({4{tv}} & ((tach_in & ~tq & {4{sc[5:4] != 2'h2}})
                                      | (~tach_in & tq & {4{sc[5:4] != 2'h1}})));
  endproperty
  a_tach: assert property (p_tach) else $error("tach pulse wrong");
  c_rclr: cover property (manager_read_clear_out);
  c_wclr: cover property (manager_write_clear_out);
  c_alert: cover property (alert_out);
  c_hold: cover property (cf[0] && !manager_record_enable_out);
endmodule
bind monitor_status_config_regs monitor_regs_properties props
(
  .clk_in, .arst_n_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_wdata_in, .reg_rdata_out,
  .host_status_any_in, .manager_status_any_in, .general_input_4_event_in, .general_input_5_event_in,
  .data_ready_in, .manager_read_clear_out, .manager_write_clear_out, .manager_clear_bits_out,
  .manager_clear_addr_out, .manager_record_enable_out, .host_record_enable_out,
  .other_events_enable_out, .duty_request_in, .duty_out, .tach_in, .tach_pulse_out, .alert_out
);
`default_nettype wire

// >>> tb/status_bank_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side status bank: one manager and one host byte at 52h
module status_bank_model
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] event_in,
  input  wire logic       manager_record_in,
  input  wire logic       host_record_in,
  input  wire logic       other_events_in,
  input  wire logic       read_clear_in,
  input  wire logic       write_clear_in,
  input  wire logic [7:0] clear_bits_in,
  input  wire logic [7:0] clear_addr_in,
  input  wire logic [7:0] host_clear_in,
  output logic      [7:0] manager_out,
  output logic      [7:0] host_out
);
  logic [7:0] seen;
  logic [7:0] wipe;
  // bit 0 and 1 are the input 4 and 5 fault flags
  assign seen = event_in & {8{other_events_in}};
  assign wipe = clear_addr_in != 8'h52 ? 8'h00 : read_clear_in ? 8'hff : write_clear_in ? clear_bits_in : 8'h00;
  // sticky bits, recorded only while the bank allows it
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      manager_out <= 8'h00;
      host_out <= 8'h00;
    end
    else
    begin
      manager_out <= (manager_out & ~wipe) | (manager_record_in ? seen : 8'h00);
      host_out <= (host_out & ~host_clear_in) | (host_record_in ? seen : 8'h00);
    end
  end
endmodule
`default_nettype wire

// >>> tb/monitor_status_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_status_config_regs_tb;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic        reg_write_in = 1'b0;
  logic        reg_read_in = 1'b0;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [7:0]  reg_rdata_out;
  logic [7:0]  ev = 8'h00;
  logic [7:0]  hclr = 8'h00;
  logic [7:0]  mst;
  logic [7:0]  hst;
  logic        data_ready_in = 1'b0;
  logic [15:0] duty_request_in = 16'h0000;
  logic [15:0] duty_out;
  logic [3:0]  tach_in = 4'h0;
  logic [3:0]  tach_pulse_out;
  logic        rclr;
  logic        wclr;
  logic        mrec;
  logic        hrec;
  logic        oth;
  logic        fan_auto;
  logic        thr;
  logic        cmp;
  logic        alert_out;
  logic [7:0]  cbits;
  logic [7:0]  caddr;
  logic [7:0]  d;
  logic [3:0]  t;
  int          miscompares = 0;
  int          n_checks = 0;
  int          seed = 29;
  int          pulses;
  int          want;
  // clock at 250 MHz
  always #2 clk_in = ~clk_in;
  monitor_status_config_regs dut
  (
    .clk_in, .arst_n_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_wdata_in, .reg_rdata_out,
    .host_status_any_in(|hst), .manager_status_any_in(|mst),
    .host_input4_fault_flag_in(hst[0]), .manager_input4_fault_flag_in(mst[0]),
    .host_input5_fault_flag_in(hst[1]), .manager_input5_fault_flag_in(mst[1]),
    .general_input_4_event_in(ev[0]), .general_input_5_event_in(ev[1]), .data_ready_in,
    .manager_read_clear_out(rclr), .manager_write_clear_out(wclr), .manager_clear_bits_out(cbits),
    .manager_clear_addr_out(caddr), .manager_record_enable_out(mrec), .host_record_enable_out(hrec),
    .other_events_enable_out(oth), .duty_request_in, .duty_out, .tach_in, .tach_pulse_out,
    .fan_auto_enable_out(fan_auto), .throttle_pin_tie_out(thr), .alert_comparator_mode_out(cmp), .alert_out
  );
  status_bank_model bank
  (
    .clk_in, .arst_n_in, .event_in(ev), .manager_record_in(mrec), .host_record_in(hrec),
    .other_events_in(oth), .read_clear_in(rclr), .write_clear_in(wclr), .clear_bits_in(cbits),
    .clear_addr_in(caddr), .host_clear_in(hclr), .manager_out(mst), .host_out(hst)
  );
  function automatic logic [15:0] exp_duty(input logic ov, input logic st, input logic [15:0] r);
    return ov ? 16'hffff : st ? r : 16'h0000;
  endfunction
  function automatic int exp_pulses(input logic [1:0] code, input logic [3:0] o, input logic [3:0] n);
    int r;
    int f;
    r = $countones(n & ~o);
    f = $countones(o & ~n);
    return (code == 2'h1) ? r : (code == 2'h2) ? f : r + f;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single-byte register cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    @(negedge clk_in);
    v = reg_rdata_out;
  endtask
  // one-cycle far-side events and host clears, then settle
  task automatic far(input logic [7:0] e, input logic [7:0] h);
    @(posedge clk_in);
    ev <= e;
    hclr <= h;
    @(posedge clk_in);
    ev <= 8'h00;
    hclr <= 8'h00;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic duty_try(input logic ov, input logic st);
    logic [15:0] r;
    wr(8'he2, {7'h00, ov});
    wr(8'he3, {7'h00, st});
    repeat (4)
    begin
      @(posedge clk_in);
      r = 16'($random(seed));
      duty_request_in <= r;
      @(posedge clk_in);
      @(negedge clk_in);
      check(duty_out, exp_duty(ov, st, r));
    end
    check(fan_auto, st);
  endtask
  // watchdog
  initial
  begin
    #200000;
    miscompares++;
    close_out;
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(8'he2, d);
    check(d, 8'h00);
    rd(8'h10, d);
    check(d, 8'h00);
    @(posedge clk_in);
    data_ready_in <= 1'b1;
    rd(8'he3, d);
    check(d, 8'h80);
    $display("reset test done");
    duty_try(1'b0, 1'b0);
    duty_try(1'b1, 1'b0);
    duty_try(1'b1, 1'b1);
    duty_try(1'b0, 1'b1);
    $display("duty test done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'he2, {2'h0, 2'(c), 4'h0});
      rd(8'he2, d);
      check(d, {2'h0, 2'(c), 4'h0});
      pulses = 0;
      want = 0;
      repeat (17)
      begin
        @(posedge clk_in);
        t = 4'($random(seed));
        want += exp_pulses(2'(c), tach_in, t);
        tach_in <= t;
        @(negedge clk_in);
        pulses += $countones(tach_pulse_out);
      end
      @(negedge clk_in);
      pulses += $countones(tach_pulse_out);
      check(16'(pulses), 16'(want));
    end
    $display("tach test done");
    wr(8'he3, 8'h09);
    wr(8'he2, 8'h00);
    far(8'h04, 8'h00);
    rd(8'h52, d);
    rd(8'he2, d);
    check(d, 8'hc0);
    check(alert_out, 1'b1);
    wr(8'h52, 8'h04);
    repeat (3) @(negedge clk_in);
    rd(8'he2, d);
    check(d, 8'h40);
    check(alert_out, 1'b0);
    far(8'h00, 8'hff);
    wr(8'he2, 8'h02);
    far(8'h04, 8'h00);
    rd(8'h52, d);
    repeat (3) @(negedge clk_in);
    rd(8'he2, d);
    check(d, 8'h42);
    wr(8'he3, 8'h01);
    far(8'h04, 8'hff);
    check(alert_out, 1'b0);
    rd(8'h52, d);
    $display("status test done");
    for (int k = 0; k < 2; k++)
    begin
      wr(8'he2, 8'(8'h04 << k));
      far(8'(8'h01 << k), 8'h00);
      check({mrec, hrec, oth}, 3'h0);
      far(8'h04, 8'h00);
      wr(8'h52, 8'(8'h01 << k));
      far(8'h00, 8'h00);
      check({mrec, hrec}, 2'h2);
      far(8'h00, 8'(8'h01 << k));
      check({mrec, hrec, oth}, 3'h7);
      far(8'h04, 8'h00);
      rd(8'he2, d);
      check(d, 8'(8'h04 << k) | 8'hc0);
      wr(8'h52, 8'hff);
      far(8'h00, 8'hff);
    end
    wr(8'he3, 8'h05);
    far(8'h01, 8'h00);
    check({mrec, oth}, 2'h0);
    $display("mask test done");
    wr(8'he2, 8'h00);
    wr(8'he3, 8'h7b);
    @(negedge clk_in);
    check({thr, cmp}, 2'h3);
    wr(8'he3, 8'h00);
    rd(8'he3, d);
    check(d, 8'h83);
    wr(8'he2, 8'hfe);
    rd(8'he2, d);
    check(d, 8'h3c);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(8'he3, d);
    check(d, 8'h80);
    $display("lock test done");
    close_out;
  end
endmodule
`default_nettype wire
